/* rtl/lvd_consts.svh */
// Register offsets, field positions and reset values of the low-voltage detector control.
// Assumes inclusion by bare name from the package and the design module.
`ifndef LVD_CONSTS_SVH
`define LVD_CONSTS_SVH
`define MODE_REG_ADDR 4'h0
`define THRESH_REG_ADDR 4'h4
`define IRQ_REG_ADDR 4'h8
`define MODE_ENABLE_BIT 7
`define MODE_SOURCE_BIT 2
`define MODE_ACTION_BIT 1
`define MODE_LEVEL_BIT 0
`define IRQ_REQUEST_BIT 0
`define IRQ_MASK_BIT 1
`define IRQ_MASK_RESET 1'b1
`define IRQ_REQUEST_RESET 1'b0
`define MODE_RESET 8'h00
`define THRESH_RESET 4'h0
`define STABLE_TIME_US 10
`define CLK_MHZ 100
`define STABLE_CYCLES (`STABLE_TIME_US * `CLK_MHZ)
`endif

/* rtl/lvd_ctl.sv */
// Control of a low-voltage detector used as interrupt or reset source, Wishbone slave.
// Assumes the comparator output is asynchronous and is synchronised here.
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`include "lvd_consts.svh"

module lvd_ctl
   import lvd_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic below_async_in,
   output logic [3:0] threshold_code_out,
   output logic source_select_bit_out,
   output logic comparator_on_out,
   output logic detector_interrupt_out,
   output logic internal_reset_out
);
   wb_req_t bus_req;
   mode_t mode_q;
   mode_t mode_d;
   logic [3:0] thresh_q;
   logic [3:0] thresh_d;
   logic mask_q;
   logic mask_d;
   logic req_q;
   logic req_d;
   logic sync1_q;
   logic sync1_d;
   logic sync2_q;
   logic sync2_d;
   logic below_q;
   logic below_d;
   logic [31:0] mode_word;
   logic [31:0] thresh_word;
   logic [31:0] irq_word;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic ack_q;
   logic ack_d;
   logic irq_q;
   logic irq_d;
   logic rst_q;
   logic rst_d;
   logic on_q;
   logic on_d;
   logic src_q;
   logic src_d;
   logic [3:0] code_q;
   logic [3:0] code_d;
   logic take;
   logic wr;
   logic rd;
   logic wr_mode;
   logic wr_thresh;
   logic wr_irq;
   logic enable_clear;
   logic irq_mode;
   logic level;
   logic crossing;
   logic stop_low;
   logic event_hit;

   // Bus request fields travel together as one carrier.
   always_comb begin
      bus_req.adr = wb_adr_in;
      bus_req.dat = wb_dat_in;
      bus_req.we = wb_we_in;
      bus_req.sel = wb_sel_in;
      bus_req.cyc = wb_cyc_in;
      bus_req.stb = wb_stb_in;
   end

   // The registered ack blocks a second take of the same request.
   assign take = bus_req.cyc && bus_req.stb && !ack_q;
   assign wr = take && bus_req.we && bus_req.sel[0];
   assign rd = take && !bus_req.we;
   assign wr_mode = wr && (bus_req.adr == `MODE_REG_ADDR);
   assign wr_thresh = wr && (bus_req.adr == `THRESH_REG_ADDR);
   assign wr_irq = wr && (bus_req.adr == `IRQ_REG_ADDR);
   assign enable_clear = wr_mode && !bus_req.dat[`MODE_ENABLE_BIT];

   // Only synchronised samples feed the level flag and the edge logic.
   assign irq_mode = !mode_q.action;
   assign level = mode_q.enable && below_q;
   assign crossing = mode_q.enable && (sync2_q != below_q);
   assign stop_low = mode_q.enable && below_q && enable_clear;
   assign event_hit = (crossing && irq_mode) || stop_low;

   // Two flip-flops resolve metastability; the third holds the previous sample.
   always_comb begin
      sync1_d = below_async_in;
      sync2_d = sync1_q;
      below_d = sync2_q;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         below_q <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         below_q <= below_d;
      end
   end

   always_comb begin
      mode_word = 32'h0;
      mode_word[`MODE_ENABLE_BIT] = mode_q.enable;
      mode_word[`MODE_SOURCE_BIT] = mode_q.source;
      mode_word[`MODE_ACTION_BIT] = mode_q.action;
      mode_word[`MODE_LEVEL_BIT] = level;
   end

   always_comb begin
      thresh_word = 32'h0;
      thresh_word[3:0] = thresh_q;
   end

   always_comb begin
      irq_word = 32'h0;
      irq_word[`IRQ_MASK_BIT] = mask_q;
      irq_word[`IRQ_REQUEST_BIT] = req_q;
   end

   // Ack is a one-cycle pulse for every taken request.
   always_comb begin
      ack_d = take;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
      end
   end

   // Read data stands with ack and reads zero outside the three registers.
   always_comb begin
      rdat_d = 32'h0;
      if (rd) begin
         case (bus_req.adr)
            `MODE_REG_ADDR: begin
               rdat_d = mode_word;
            end
            `THRESH_REG_ADDR: begin
               rdat_d = thresh_word;
            end
            `IRQ_REG_ADDR: begin
               rdat_d = irq_word;
            end
            default: begin
               rdat_d = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rdat_q <= 32'h0;
      end else begin
         rdat_q <= rdat_d;
      end
   end

   always_comb begin
      mode_d = mode_q;
      if (wr_mode) begin
         mode_d.enable = bus_req.dat[`MODE_ENABLE_BIT];
         mode_d.source = bus_req.dat[`MODE_SOURCE_BIT];
         mode_d.action = bus_req.dat[`MODE_ACTION_BIT];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         mode_q <= '0;
      end else begin
         mode_q <= mode_d;
      end
   end

   always_comb begin
      thresh_d = thresh_q;
      if (wr_thresh) begin
         thresh_d = bus_req.dat[3:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         thresh_q <= `THRESH_RESET;
      end else begin
         thresh_q <= thresh_d;
      end
   end

   // A hardware event wins over a software clear in the same cycle.
   always_comb begin
      mask_d = mask_q;
      req_d = req_q;
      if (wr_irq) begin
         mask_d = bus_req.dat[`IRQ_MASK_BIT];
         req_d = bus_req.dat[`IRQ_REQUEST_BIT];
      end
      if (event_hit) begin
         req_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         mask_q <= `IRQ_MASK_RESET;
         req_q <= `IRQ_REQUEST_RESET;
      end else begin
         mask_q <= mask_d;
         req_q <= req_d;
      end
   end

   // The interrupt output is a one-cycle pulse per event.
   always_comb begin
      irq_d = event_hit;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // Internal reset follows the new mode at once, so it never outlives the enable.
   always_comb begin
      rst_d = mode_d.enable && mode_d.action && below_q;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rst_q <= 1'b0;
      end else begin
         rst_q <= rst_d;
      end
   end

   // Mirror outputs show the register contents from the edge that writes them.
   always_comb begin
      on_d = mode_d.enable;
      src_d = mode_d.source;
      code_d = thresh_d;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         on_q <= 1'b0;
         src_q <= 1'b0;
         code_q <= `THRESH_RESET;
      end else begin
         on_q <= on_d;
         src_q <= src_d;
         code_q <= code_d;
      end
   end

   assign wb_dat_out = rdat_q;
   assign wb_ack_out = ack_q;
   assign detector_interrupt_out = irq_q;
   assign internal_reset_out = rst_q;
   assign comparator_on_out = on_q;
   assign source_select_bit_out = src_q;
   assign threshold_code_out = code_q;
endmodule

/* rtl/lvd_pkg.sv */
// Types shared by the low-voltage detector control.
// Assumes the constants header sits beside it.
`include "lvd_consts.svh"
package lvd_pkg;
   typedef struct packed {
      logic enable;
      logic source;
      logic action;
   } mode_t;
   typedef struct packed {
      logic [3:0] adr;
      logic [31:0] dat;
      logic we;
      logic [3:0] sel;
      logic cyc;
      logic stb;
   } wb_req_t;
endpackage

/* verification/lvd_ctl_chk.sv */
// Port checker for the detector control.
// Assumes a bind onto lvd_ctl.
`timescale 1ns/1ns
module lvd_ctl_chk(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic [3:0] threshold_code_out,
   input wire logic source_select_bit_out,
   input wire logic comparator_on_out,
   input wire logic detector_interrupt_out,
   input wire logic internal_reset_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   wire logic tk = wb_cyc_in && wb_stb_in && !wb_ack_out;
   wire logic wm = tk && wb_we_in && wb_sel_in[0] && wb_adr_in == 4'h0;
   a_ack_next: assert property (tk |=> wb_ack_out) else $error("ack late");
   a_ack_once: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
   a_enable_wr: assert property (wm |=> comparator_on_out == $past(wb_dat_in[7]))
      else $error("enable");
   a_source_wr: assert property (wm |=> source_select_bit_out == $past(wb_dat_in[2]))
      else $error("source");
   a_thresh_wr: assert property (tk && wb_we_in && wb_sel_in[0] && wb_adr_in == 4'h4
      |=> threshold_code_out == $past(wb_dat_in[3:0])) else $error("thresh");
   a_irq_pulse: assert property (detector_interrupt_out |=> !detector_interrupt_out)
      else $error("irq");
   a_reset_gate: assert property (internal_reset_out |-> comparator_on_out)
      else $error("reset");
   a_upper_zero: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
      else $error("upper");
endmodule
bind lvd_ctl lvd_ctl_chk u_chk(.*);

/* verification/testbench.sv */
// Bench for the detector control over Wishbone.
// Assumes the comparator input is driven here.
`timescale 1ns/1ns
`include "lvd_consts.svh"
module testbench;
   import lvd_pkg::*;
   logic clk_in = 0, rstn_in = 0, we = 0, cs = 0, below = 0;
   logic [3:0] adr = 4'h0, thr;
   logic [3:0] sel = 4'hf;
   logic [31:0] dat = 32'h0, q;
   logic ack, src, on, irq, ires;
   int errors = 0, total_checks = 0, pulses = 0;
   lvd_ctl u_dut(.clk_in(clk_in), .rstn_in(rstn_in), .wb_adr_in(adr), .wb_dat_in(dat),
      .wb_we_in(we), .wb_sel_in(sel), .wb_cyc_in(cs), .wb_stb_in(cs), .wb_dat_out(q),
      .wb_ack_out(ack), .below_async_in(below), .threshold_code_out(thr),
      .source_select_bit_out(src), .comparator_on_out(on),
      .detector_interrupt_out(irq), .internal_reset_out(ires));
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (irq === 1'b1) begin
         pulses++;
      end
   end
   task automatic test_done;
      if (errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w,
      output logic [31:0] r);
      int n;
      adr <= a;
      dat <= d;
      we <= w;
      cs <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         errors++;
         test_done;
      end
      r = q;
      cs <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, d, 1'b1, r);
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(a, 32'h0, 1'b0, r);
      chk(r, e);
   endtask
   task automatic hold(input logic b);
      below <= b;
      repeat (6) @(posedge clk_in);
   endtask
   initial begin
      repeat (8) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      rc(4'h8, 32'h2);
      rc(4'h0, 32'h0);
      rc(4'hc, 32'h0);
      wr(4'h8, 32'h2);
      wr(4'h4, 32'h5);
      chk({28'h0, thr}, 32'h5);
      sel <= 4'he;
      wr(4'h4, 32'ha);
      sel <= 4'hf;
      rc(4'h4, 32'h5);
      wr(4'h0, 32'h84);
      chk({30'h0, src, on}, 32'h3);
      repeat (`STABLE_CYCLES) @(posedge clk_in);
      rc(4'h0, 32'h84);
      wr(4'h8, 32'h2);
      wr(4'h8, 32'h0);
      wr(4'h0, 32'h84);
      hold(1'b1);
      rc(4'h0, 32'h85);
      chk(32'(pulses), 32'h1);
      rc(4'h8, 32'h1);
      wr(4'h8, 32'h0);
      hold(1'b0);
      chk(32'(pulses), 32'h2);
      rc(4'h0, 32'h84);
      hold(1'b1);
      wr(4'h8, 32'h0);
      wr(4'h0, 32'h0);
      rc(4'h0, 32'h0);
      hold(1'b1);
      chk(32'(pulses), 32'h4);
      rc(4'h8, 32'h1);
      rstn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      rc(4'h8, 32'h2);
      wr(4'h0, 32'h82);
      hold(1'b1);
      chk({31'h0, ires}, 32'h1);
      hold(1'b0);
      chk({31'h0, ires}, 32'h0);
      chk(32'(pulses), 32'h4);
      test_done;
   end
endmodule
